// ===== src/sent_pkg.sv
package sent_pkg;

   localparam int ADDR_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CON1 = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CON2 = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_CON3 = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STAT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_DATL = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_DATH = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_SYNC = 8'h18;

   // Control one field positions
   localparam int B_EN = 15;
   localparam int B_SIDL = 13;
   localparam int B_RCV = 11;
   localparam int B_TRIG = 10;
   localparam int B_POL = 9;
   localparam int B_CRC = 8;
   localparam int B_PAUSE = 7;
   localparam int B_SPC = 6;
   localparam int B_PS = 4;
   localparam logic [15:0] CON1_WMASK = 16'hafd7;

   // Status field positions
   localparam int S_PAUSE_B = 7;
   localparam int S_CHECKSUM_ERROR_FLAG_B = 3;
   localparam int S_FRAMING_ERROR_FLAG_B = 2;
   localparam int S_IDLE_B = 1;
   localparam int S_GO_B = 0;

   // Timing in ticks and prescaled clocks
   localparam logic [10:0] SYNC_TICKS = 11'h038;
   localparam logic [10:0] NIB_BASE = 11'h00c;
   localparam logic [10:0] LOW_TICKS = 11'h005;
   localparam logic [10:0] PAUSE_MIN = 11'h00c;
   localparam logic [11:0] FRAME_MAX = 12'h7ff;
   localparam logic [1:0] PRESC_LAST = 2'h3;
   localparam logic [2:0] POS_CRC = 3'h7;
   localparam logic [3:0] CRC_SEED = 4'h5;
   localparam logic [4:0] CRC_POLY = 5'h1d;

   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_SYNC = 7'b0000010,
      S_NIB = 7'b0000100,
      S_PAUSE = 7'b0001000,
      S_END = 7'b0010000,
      S_HUNT = 7'b0100000,
      S_RXNIB = 7'b1000000
   } phase_t;

   typedef struct packed {
      logic [15:0] con1;
      logic [15:0] con2;
      logic [15:0] con3;
      logic [15:0] datl;
      logic [15:0] dath;
      logic [15:0] sync_cap;
      logic err_crc;
      logic err_frm;
      logic idle_f;
      logic pause_f;
      logic go;
      logic spc_armed;
      phase_t st;
      logic [2:0] pos;
      logic [1:0] presc;
      logic [15:0] tick;
      logic [10:0] tcnt;
      logic [10:0] plen;
      logic [11:0] ftick;
      logic [15:0] meas;
      logic rx_d;
      logic txo;
      logic done;
      logic wr_pend;
      logic [ADDR_W-1:0] wr_addr;
      logic [31:0] hrdata;
      logic hready;
      logic hresp;
   } regs_t;

endpackage

// ===== src/sent_crc4.sv
module sent_crc4 #(
   parameter int MAX_NIB = 6
) (
   input wire logic [4*MAX_NIB-1:0] i_data, // Data nibble one in top bits
   input wire logic [2:0] i_count,          // Data nibbles in use
   output logic [3:0] o_crc                 // Checksum nibble
);
   import sent_pkg::*;

   function automatic logic [3:0] mul16(input logic [3:0] c);
      logic [4:0] v;
      v = {1'b0, c};
      for (int i = 0; i < 4; i++) begin
         v = {v[3:0], 1'b0};
         if (v[4]) begin
            v = v ^ CRC_POLY;
         end
      end
      return v[3:0];
   endfunction

   logic [3:0] chain [0:MAX_NIB];

   assign chain[0] = CRC_SEED;

   // Status nibble is excluded; unused nibbles pass the chain through
   for (genvar k = 0; k < MAX_NIB; k++) begin : g_stage
      assign chain[k+1] = (k < int'(i_count)) ?
         (mul16(chain[k]) ^ i_data[4*(MAX_NIB-1-k) +: 4]) : chain[k];
   end

   // Augment with a zero nibble
   assign o_crc = mul16(chain[MAX_NIB]);

endmodule

// ===== src/sent_nibble_transceiver.sv
// Contract
// RL1: Pause never below 12 ticks; period capped 2047
// RL2: Software keeps frame period above both minima
// RL3: Software configures fully before setting enable
// RL4: Software reloads transmit data between frames
// RL5: Sync accepted only inside programmed limits, captured
// RL6: Nibbles checked, stored, completion event raised
// RL7: Software derives sync limits from tick period
// RL8: Software keeps lower limit below upper limit
// RL9: Software configures receiver before setting enable
// RL10: Software reads data between received frames
// RL11: Control bit 15 enables the module
// RL12: Control bit 13 halts during device idle
// RL13: Control bit 11 selects receive, else transmit
// RL14: Triggered mode and idle polarity, transmit only
// RL15: Control bit 8 enables hardware checksum
// RL16: Control bit 7 adds pause period
// RL17: Control bit 6 gates short PWM trigger
// RL18: Control bit 4 divides clock by four
// RL19: Nibble count field selects one to six; the code also takes 0 (no data nibbles) and 7 (acts as six)
// RL20: Status bit 7 flags pause period
// RL21: Transmit nibble position encoded in status
// RL22: Receive position shown, kept on error
// RL23: Framing and checksum errors set clearable flags
// RL24: Idle flag when line high past upper limit
// RL25: Sync 56 ticks, nibbles value plus 12
// RL26: Trigger bit launches frame, reads busy
// RL27: High data word holds status, data one-three
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
module sent_nibble_transceiver (
   input wire logic I_CLOCK,                         // 125 MHz clock
   input wire logic I_ARST_N,                        // Async reset
   input wire logic I_CE,                            // Freezes all when low
   input wire logic I_IDLE_MODE,                     // Device idle mode
   input wire logic I_RX,                            // Line input
   input wire logic I_SPC_START,                     // External SPC pulse
   input wire logic I_HSEL,                          // AHB select
   input wire logic [31:0] I_HADDR,                  // AHB address
   input wire logic [1:0] I_HTRANS,                  // AHB transfer type
   input wire logic I_HWRITE,                        // AHB write
   input wire logic [2:0] I_HSIZE,                   // AHB size
   input wire logic [31:0] I_HWDATA,                 // AHB write data
   input wire logic I_HREADY,                        // AHB ready in
   output logic [31:0] O_HRDATA,                     // AHB read data
   output logic O_HREADYOUT,                         // AHB ready out
   output logic O_HRESP,                             // AHB response
   output logic O_TX,                                // Line output
   output logic O_FRAME_DONE,                        // Frame event pulse
   output logic [sent_pkg::ADDR_W-1:0] O_DUMMY_NONE  // Last address seen
);
   import sent_pkg::*;

   regs_t r;
   regs_t n;
   logic [3:0] crc_calc;
   logic [16:0] ge;
   logic [23:0] mm;
   logic en, sidl, rcv, triggered_transmit_mode, pol, hw_checksum_enable, pause_pulse_present, short_pwm_code_enable, ps;
   logic [2:0] ncnt;
   logic pre_stb, tick_stb, fall, ferr, sync_ok, halt, sel;
   logic [3:0] nv;
   logic [11:0] fpe;

   assign en = r.con1[B_EN];
   assign sidl = r.con1[B_SIDL];
   assign rcv = r.con1[B_RCV];
   assign triggered_transmit_mode = r.con1[B_TRIG];
   assign pol = r.con1[B_POL];
   assign hw_checksum_enable = r.con1[B_CRC];
   assign pause_pulse_present = r.con1[B_PAUSE];
   assign short_pwm_code_enable = r.con1[B_SPC];
   assign ps = r.con1[B_PS];
   assign ncnt = r.con1[2:0];
   assign halt = sidl && I_IDLE_MODE;                       // see RL12
   assign pre_stb = !ps || (r.presc == PRESC_LAST);         // see RL18
   assign tick_stb = pre_stb && (r.tick == r.con2);
   assign fall = r.rx_d && !I_RX;
   assign sync_ok = (r.meas >= r.con3) && (r.meas <= r.con2); // see RL5
   assign fpe = (r.con3 > 16'(FRAME_MAX)) ? FRAME_MAX : r.con3[11:0]; // see RL1
   assign sel = I_HSEL && I_HTRANS[1] && I_HREADY;

   sent_crc4 #(.MAX_NIB(6)) u_crc (
      .i_data({r.dath[11:0], r.datl[15:4]}),
      .i_count(ncnt),
      .o_crc(crc_calc)
   );

   // Half-tick thresholds avoid a divider: nibble value is a comparator count
   assign mm = {1'b0, r.meas, 7'h00} - {4'h0, r.meas, 4'h0};
   for (genvar k = 0; k <= 16; k++) begin : g_thr
      assign ge[k] = mm >= ({8'h00, r.sync_cap} * 24'(2 * k + 23));
   end
   assign nv = 4'($countones(ge[15:1]));
   assign ferr = !ge[0] || ge[16];                          // see RL23

   function automatic logic [3:0] nib(input regs_t s, input logic [2:0] p);
      logic [31:0] w;
      w = {s.dath, s.datl};
      return w[{~p, 2'b00} +: 4];                           // see RL27
   endfunction

   function automatic logic [10:0] plen_pause(input logic [11:0] fp,
                                              input logic [11:0] used);
      logic [11:0] d;
      d = fp - used;
      if (fp < used + 12'(PAUSE_MIN)) begin
         return PAUSE_MIN;                                  // see RL1
      end
      return d[10:0];
   endfunction

   always_comb begin
      logic [31:0] w;
      logic [2:0] np;
      logic low;
      w = {r.dath, r.datl};
      np = 3'h0;
      low = 1'b0;
      n = r;
      n.done = 1'b0;
      n.hready = 1'b1;
      if (r.wr_pend) begin
         if (r.wr_addr == OFF_CON1) begin
            n.con1 = I_HWDATA[15:0] & CON1_WMASK;           // see RL19
         end else if (r.wr_addr == OFF_CON2) begin
            n.con2 = I_HWDATA[15:0];
         end else if (r.wr_addr == OFF_CON3) begin
            n.con3 = I_HWDATA[15:0];
         end else if (r.wr_addr == OFF_STAT) begin
            if (!I_HWDATA[S_CHECKSUM_ERROR_FLAG_B]) n.err_crc = 1'b0;
            if (!I_HWDATA[S_FRAMING_ERROR_FLAG_B]) n.err_frm = 1'b0;
            if (!rcv && triggered_transmit_mode && I_HWDATA[S_GO_B]) n.go = 1'b1; // see RL26
         end else if (r.wr_addr == OFF_DATL && !rcv) begin
            n.datl = hw_checksum_enable ? {I_HWDATA[15:4], r.datl[3:0]} : I_HWDATA[15:0];
         end else if (r.wr_addr == OFF_DATH && !rcv) begin
            n.dath = I_HWDATA[15:0];
         end
      end
      if (!en) begin                                        // see RL11
         n.st = S_IDLE;
         n.pos = 3'h0;
         n.tcnt = 11'h000;
         n.tick = 16'h0000;
         n.presc = 2'h0;
         n.meas = 16'h0000;
         n.pause_f = 1'b0;
         n.idle_f = 1'b0;
         n.rx_d = 1'b1;
      end else if (!halt) begin
         n.presc = r.presc + 2'h1;
         if (!rcv) begin                                    // see RL13
            n.idle_f = 1'b0;
            if (pre_stb) n.tick = tick_stb ? 16'h0000 : r.tick + 16'h0001;
            if (r.st == S_IDLE || r.st == S_HUNT || r.st == S_RXNIB) begin
               n.st = S_IDLE;
               n.presc = 2'h0;                      // Keeps first tick whole
               n.tick = 16'h0000;
               n.tcnt = 11'h000;
               n.pos = 3'h0;
               if (!triggered_transmit_mode || r.go) begin                      // see RL14
                  n.st = S_SYNC;
                  n.plen = SYNC_TICKS;                      // see RL25
                  n.ftick = 12'h000;
               end
            end else if (tick_stb) begin
               if (r.ftick != 12'hfff) n.ftick = r.ftick + 12'h001;
               if (r.tcnt != r.plen - 11'h001) begin
                  n.tcnt = r.tcnt + 11'h001;
               end else begin
                  n.tcnt = 11'h000;
                  case (r.st)
                     S_SYNC: begin
                        n.st = S_NIB;
                        n.pos = 3'h0;
                        n.plen = NIB_BASE + 11'(nib(r, 3'h0)); // see RL25
                     end
                     S_NIB: begin
                        if (r.pos == POS_CRC) begin
                           n.done = 1'b1;
                           n.pos = 3'h0;
                           if (pause_pulse_present) begin                   // see RL16
                              n.st = S_PAUSE;
                              n.plen = plen_pause(fpe, r.ftick + 12'h001);
                           end else if (triggered_transmit_mode) begin
                              n.st = S_END;
                              n.plen = LOW_TICKS;
                           end else begin
                              n.st = S_SYNC;
                              n.plen = SYNC_TICKS;
                              n.ftick = 12'h000;
                           end
                        end else begin
                           np = (r.pos == ncnt) ? POS_CRC : r.pos + 3'h1;
                           n.pos = np;                      // see RL21
                           if (np == POS_CRC && hw_checksum_enable) begin
                              n.datl[3:0] = crc_calc;       // see RL15
                              n.plen = NIB_BASE + 11'(crc_calc);
                           end else begin
                              n.plen = NIB_BASE + 11'(nib(r, np));
                           end
                        end
                     end
                     S_PAUSE: begin
                        n.st = triggered_transmit_mode ? S_END : S_SYNC;
                        n.plen = triggered_transmit_mode ? LOW_TICKS : SYNC_TICKS;
                        n.ftick = 12'h000;
                     end
                     default: begin
                        n.st = S_IDLE;
                        n.go = 1'b0;                        // see RL26
                     end
                  endcase
               end
            end
         end else begin
            n.rx_d = I_RX;
            if (pre_stb && r.meas != 16'hffff) n.meas = r.meas + 16'h0001;
            if (I_SPC_START && short_pwm_code_enable) n.spc_armed = 1'b1;   // see RL17
            if (r.st != S_HUNT && r.st != S_RXNIB) n.st = S_HUNT;
            if (fall) begin
               n.meas = {15'h0000, pre_stb};        // see RL5
               if (r.st == S_RXNIB) begin
                  if (ferr) begin
                     n.err_frm = 1'b1;                      // see RL23
                     n.st = S_HUNT;                         // see RL22
                  end else begin
                     w[{~r.pos, 2'b00} +: 4] = nv;          // see RL6
                     n.dath = w[31:16];
                     n.datl = w[15:0];
                     if (r.pos == POS_CRC) begin
                        if (hw_checksum_enable && nv != crc_calc) n.err_crc = 1'b1;
                        n.done = 1'b1;
                        n.pos = 3'h0;
                        n.st = S_HUNT;
                        n.pause_f = pause_pulse_present;                    // see RL20
                     end else begin
                        n.pos = (r.pos == ncnt) ? POS_CRC : r.pos + 3'h1;
                     end
                  end
               end else begin
                  n.pause_f = 1'b0;
                  if (sync_ok && (!short_pwm_code_enable || r.spc_armed)) begin
                     n.st = S_RXNIB;
                     n.sync_cap = r.meas;                   // see RL5
                     n.pos = 3'h0;
                     n.spc_armed = 1'b0;
                  end
               end
            end
            n.idle_f = I_RX && (r.meas >= r.con2);          // see RL24
         end
      end
      low = (n.st == S_SYNC || n.st == S_NIB || n.st == S_PAUSE ||
             n.st == S_END) && (n.tcnt < LOW_TICKS);
      n.txo = !low ^ pol;                                   // see RL14
      n.wr_pend = sel && I_HWRITE;
      if (sel) n.wr_addr = I_HADDR[ADDR_W-1:0];
      if (sel && !I_HWRITE) begin
         n.hrdata = 32'h00000000;
         if (I_HADDR[ADDR_W-1:0] == OFF_CON1) begin
            n.hrdata[15:0] = n.con1;
         end else if (I_HADDR[ADDR_W-1:0] == OFF_CON2) begin
            n.hrdata[15:0] = n.con2;
         end else if (I_HADDR[ADDR_W-1:0] == OFF_CON3) begin
            n.hrdata[15:0] = n.con3;
         end else if (I_HADDR[ADDR_W-1:0] == OFF_STAT) begin
            n.hrdata[S_PAUSE_B] = rcv ? n.pause_f : (n.st == S_PAUSE);
            n.hrdata[6:4] = (rcv || n.st == S_NIB) ? n.pos : 3'h0;
            n.hrdata[S_CHECKSUM_ERROR_FLAG_B] = n.err_crc;
            n.hrdata[S_FRAMING_ERROR_FLAG_B] = n.err_frm;
            n.hrdata[S_IDLE_B] = n.idle_f;
            n.hrdata[S_GO_B] = rcv ? (n.st == S_RXNIB) :
                               (triggered_transmit_mode ? n.go : en);
         end else if (I_HADDR[ADDR_W-1:0] == OFF_DATL) begin
            n.hrdata[15:0] = n.datl;
         end else if (I_HADDR[ADDR_W-1:0] == OFF_DATH) begin
            n.hrdata[15:0] = n.dath;
         end else if (I_HADDR[ADDR_W-1:0] == OFF_SYNC) begin
            n.hrdata[15:0] = n.sync_cap;
         end
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         r <= '0;
         r.st <= S_IDLE;
         r.rx_d <= 1'b1;
         r.txo <= 1'b1;
         r.hready <= 1'b1;
      end else if (I_CE) begin
         r <= n;
      end
   end

   assign O_HRDATA = r.hrdata;
   assign O_HREADYOUT = r.hready;
   assign O_HRESP = r.hresp;
   assign O_TX = r.txo;
   assign O_FRAME_DONE = r.done;
   assign O_DUMMY_NONE = r.wr_addr;

   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_ARST_N);

   pause_floor_a: assert property ( // see RL1
      (r.st != S_PAUSE) ##1 (r.st == S_PAUSE) |-> r.plen >= PAUSE_MIN)
      else $error("pause shorter than minimum");
   sync_len_a: assert property ( // see RL25
      $changed(r.st) && r.st == S_SYNC |-> r.plen == SYNC_TICKS)
      else $error("sync period not 56 ticks");
   nib_len_a: assert property ( // see RL25
      r.st == S_NIB |-> r.plen >= NIB_BASE && r.plen <= NIB_BASE + 11'h00f)
      else $error("nibble length out of range");
   sync_window_a: assert property ( // see RL5
      $past(r.st) == S_HUNT && r.st == S_RXNIB |->
      r.sync_cap >= r.con3 && r.sync_cap <= r.con2)
      else $error("sync accepted outside limits");
   rx_done_a: assert property ( // see RL6
      $rose(r.done) && rcv |-> $past(r.pos) == POS_CRC)
      else $error("receive frame end not after checksum");
   disable_idle_a: assert property ( // see RL11
      I_CE && !en |=> r.st == S_IDLE)
      else $error("disabled module not idle");
   stop_idle_a: assert property ( // see RL12
      I_CE && en && halt && !r.wr_pend |=> $stable(r.tcnt) && $stable(r.st))
      else $error("module ran in device idle");
   idle_level_a: assert property ( // see RL14
      $past(I_CE) && r.st == S_IDLE && $past(r.st == S_IDLE) &&
      $stable(r.con1) |-> r.txo == !pol)
      else $error("idle line level wrong");
   frm_err_a: assert property ( // see RL23
      $rose(r.err_frm) |-> $past(ferr && fall && r.st == S_RXNIB))
      else $error("framing flag without cause");
   line_idle_a: assert property ( // see RL24
      r.idle_f |-> $past(I_RX && r.meas >= r.con2))
      else $error("idle flag without long high");

   tx_frame_c: cover property (!rcv && $rose(r.done));
   rx_frame_c: cover property (rcv && $rose(r.done));
   crc_err_c: cover property ($rose(r.err_crc));
   pause_c: cover property (r.st == S_PAUSE ##1 r.st == S_SYNC);

endmodule

// ===== sim/sent_line_model.sv
module sent_line_model (
   input wire logic i_clk,         // Bench clock
   input wire logic i_start,       // Send one frame
   input wire logic [7:0] i_tick,  // Clocks per tick
   input wire logic [3:0] i_count, // Nibble periods after the sync
   input wire logic [39:0] i_nib,  // Ticks above 12, status first
   output logic o_line,            // Line level, pulled high
   output logic o_busy             // Frame in flight
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_line = 1'b1;
      o_busy = 1'b0;
   end

   // Every period opens with a falling edge and a short low pulse
   task automatic period(input int ticks);
      o_line <= 1'b0;
      repeat (5 * i_tick) @(posedge i_clk);
      o_line <= 1'b1;
      repeat ((ticks - 5) * i_tick) @(posedge i_clk);
   endtask

   always @(posedge i_clk) begin
      if (i_start && !o_busy) begin
         o_busy <= 1'b1;
         period(56);
         for (int k = 0; k < i_count; k++) begin
            period(12 + int'(i_nib[39-5*k -: 5]));
         end
         // Closing edge is needed, else the checksum nibble never ends
         period(5);
         o_busy <= 1'b0;
      end
   end
endmodule

// ===== sim/sent_nibble_transceiver_tb_top.sv
module sent_nibble_transceiver_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sent_pkg::*;
`define CHK(nm, e, g) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
   end \
end
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready, hresp, tx, done, line, m_busy;
   logic tx_d = 1'b1;
   logic idle_mode = 1'b0;
   logic spc = 1'b0;
   logic [7:0] last_a;
   logic m_start = 1'b0;
   logic [7:0] m_tick = 8'h04;
   logic [39:0] m_nib = 40'h0;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int done_cnt = 0;

   always #4 clk = ~clk;

   sent_nibble_transceiver sent_nibble_transceiver_inst (
      .I_CLOCK(clk), .I_ARST_N(rst_n), .I_CE(1'b1), .I_IDLE_MODE(idle_mode),
      .I_RX(line), .I_SPC_START(spc), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010),
      .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
      .O_HREADYOUT(hready), .O_HRESP(hresp), .O_TX(tx),
      .O_FRAME_DONE(done), .O_DUMMY_NONE(last_a));

   sent_line_model sent_line_model_inst (
      .i_clk(clk), .i_start(m_start), .i_tick(m_tick), .i_count(4'h5),
      .i_nib(m_nib), .o_line(line), .o_busy(m_busy));

   always @(posedge clk) begin
      tx_d <= tx;
      cyc++;
      if (done === 1'b1) begin
         done_cnt++;
      end
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask

   // Checksum over data nibbles only, closed by one zero nibble
   function automatic logic [3:0] crc4(input logic [23:0] d, input int n);
      logic [3:0] c;
      logic [3:0] v;
      c = 4'h5;
      for (int k = 0; k <= n; k++) begin
         v = (k < n) ? d[23-4*k -: 4] : 4'h0;
         for (int i = 3; i >= 0; i--) begin
            c = {c[2:0], v[i]} ^ (c[3] ? 4'hd : 4'h0);
         end
      end
      return c;
   endfunction

   // Sampled 1 ns after the edge so both the line and its delay settled
   task automatic fall(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (!(tx_d === 1'b1 && tx === 1'b0));
   endtask

   task automatic gaps(input int g[6], input int cnt);
      int n;
      fall(n);
      for (int k = 0; k < cnt; k++) begin
         fall(n);
         `CHK("gap", g[k], n)
      end
   endtask

   task automatic send(input logic [7:0] t, input logic [39:0] nb);
      @(posedge clk);
      m_tick <= t;
      m_nib <= nb;
      m_start <= 1'b1;
      @(posedge clk);
      m_start <= 1'b0;
      do @(posedge clk); while (m_busy === 1'b1);
      repeat (4) @(posedge clk);
   endtask

   task automatic t_regs();
      logic [31:0] r;
      rd(OFF_CON1, r);
      `CHK("con1 reset", 32'h0, r)
      rd(OFF_STAT, r);
      `CHK("stat reset", 32'h0, r)
      wr(OFF_CON1, 32'h7fff);
      rd(OFF_CON1, r);
      `CHK("con1 mask", 32'h2fd7, r)
      wr(OFF_CON1, 32'h0);
      wr(8'h1c, 32'hffff);
      rd(8'h1c, r);
      `CHK("unmapped", 32'h0, r)
      `CHK("last addr", 8'h1c, last_a)
      `CHK("hresp", 1'b0, hresp)
      $display("test regs done");
   endtask

   task automatic t_tx_cont();
      int g[6];
      logic [3:0] c;
      logic [31:0] r;
      c = crc4(24'h230000, 2);
      // Frame period 10 is far too short, so the pause is its floor
      g = '{224, 52, 56, 60, 48 + 4 * int'(c), 48};
      wr(OFF_CON2, 32'h3);
      wr(OFF_CON3, 32'd10);
      wr(OFF_DATH, 32'h1234);
      wr(OFF_CON1, 32'h8182);
      gaps(g, 6);
      rd(OFF_STAT, r);
      `CHK("go cont", 1'b1, r[S_GO_B])
      wr(OFF_CON1, 32'h0);
      $display("test tx continuous done");
   endtask

   task automatic t_tx_trig();
      int g[6];
      logic [31:0] r;
      int d0;
      g = '{224, 48, 48, 76, 0, 0};
      wr(OFF_CON2, 32'h0);
      wr(OFF_DATH, 32'h0);
      wr(OFF_DATL, 32'h7);
      wr(OFF_CON1, 32'h8411);
      rd(OFF_STAT, r);
      `CHK("go idle", 1'b0, r[S_GO_B])
      d0 = done_cnt;
      wr(OFF_STAT, 32'h1);
      gaps(g, 4);
      rd(OFF_STAT, r);
      `CHK("go busy", 1'b1, r[S_GO_B])
      repeat (40) @(posedge clk);
      rd(OFF_STAT, r);
      `CHK("go clear", 1'b0, r[S_GO_B])
      `CHK("tx done", d0 + 1, done_cnt)
      wr(OFF_CON1, 32'h0200);
      // Polarity landed at the write's last edge, the line follows at the next edge
      repeat (2) @(posedge clk);
      `CHK("idle low", 1'b0, tx)
      $display("test tx triggered done");
   endtask

   task automatic t_idle();
      int n;
      wr(OFF_CON2, 32'h3);
      wr(OFF_CON3, 32'd872);
      wr(OFF_CON1, 32'ha182);
      idle_mode <= 1'b1;
      repeat (300) @(posedge clk);
      idle_mode <= 1'b0;
      fall(n);
      `CHK("idle hold", 1, n)
      fall(n);
      `CHK("idle sync", 224, n)
      wr(OFF_CON1, 32'h0);
      $display("test idle done");
   endtask

   task automatic t_rx();
      logic [3:0] c;
      logic [31:0] r;
      int d0;
      c = crc4(24'h123000, 3);
      wr(OFF_CON2, 32'd269);
      wr(OFF_CON3, 32'd179);
      wr(OFF_CON1, 32'h8903);
      d0 = done_cnt;
      send(8'h4, {5'h0a, 5'h01, 5'h02, 5'h03, 1'b0, c, 15'h0});
      `CHK("rx done", d0 + 1, done_cnt)
      rd(OFF_DATH, r);
      `CHK("rx high", 32'ha123, r)
      rd(OFF_SYNC, r);
      `CHK("rx sync", 32'd224, r)
      rd(OFF_STAT, r);
      `CHK("rx pos", 3'h0, r[6:4])
      `CHK("rx crc ok", 1'b0, r[S_CHECKSUM_ERROR_FLAG_B])
      send(8'h4, {5'h0a, 5'h01, 5'h02, 5'h03, 1'b0, ~c, 15'h0});
      rd(OFF_STAT, r);
      `CHK("crc err", 1'b1, r[S_CHECKSUM_ERROR_FLAG_B])
      wr(OFF_STAT, 32'h0);
      rd(OFF_STAT, r);
      `CHK("crc clear", 1'b0, r[S_CHECKSUM_ERROR_FLAG_B])
      send(8'h4, {5'h0a, 5'h01, 5'h12, 5'h03, 1'b0, c, 15'h0});
      rd(OFF_STAT, r);
      `CHK("frm err", 1'b1, r[S_FRAMING_ERROR_FLAG_B])
      `CHK("frm pos", 3'h2, r[6:4])
      d0 = done_cnt;
      // Sync of 168 and 280 clocks, each just outside the limits
      for (int t = 3; t <= 5; t += 2) begin
         send(t[7:0], {5'h0a, 5'h01, 5'h02, 5'h03, 1'b0, c, 15'h0});
      end
      `CHK("sync range", d0, done_cnt)
      wr(OFF_CON1, 32'h8943);
      d0 = done_cnt;
      send(8'h4, {5'h0a, 5'h01, 5'h02, 5'h03, 1'b0, c, 15'h0});
      `CHK("spc held", d0, done_cnt)
      spc <= 1'b1;
      @(posedge clk);
      spc <= 1'b0;
      send(8'h4, {5'h0a, 5'h01, 5'h02, 5'h03, 1'b0, c, 15'h0});
      `CHK("spc armed", d0 + 1, done_cnt)
      repeat (300) @(posedge clk);
      rd(OFF_STAT, r);
      `CHK("line idle", 1'b1, r[S_IDLE_B])
      wr(OFF_CON1, 32'h0);
      $display("test rx done");
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_tx_cont();
      t_tx_trig();
      t_idle();
      t_rx();
      end_sim();
   end
endmodule
